// ===== core/pwrc_map.svh
// constants of the power state and ready control block
// assumes a 10 mhz core clock and active low asynchronous reset
`ifndef PWRC_MAP_SVH
`define PWRC_MAP_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PWRC_CLK_PERIOD_NS 100
`define PWRC_HOLDOFF_MS 50
`define PWRC_HOLDOFF_CYCLES ((`PWRC_HOLDOFF_MS * 1000000) / `PWRC_CLK_PERIOD_NS)
`define PWRC_READY_DELAY_US 100
`define PWRC_READY_DELAY_CYCLES ((`PWRC_READY_DELAY_US * 1000) / `PWRC_CLK_PERIOD_NS)
`define PWRC_CNT_W 20

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define PWRC_CODE_W 8
`define PWRC_CHAN_N 3
`define PWRC_CHAN3 2
`define PWRC_CODE_RST 8'hff
`define PWRC_RAIL_575 1'b0
`define PWRC_RAIL_775 1'b1

`endif

// ===== core/pwrc_pkg.sv
// types of the power state and ready control block
// assumes pwrc_map.svh is on the include path
package pwrc_pkg;
	typedef enum logic [1:0] {
		PWRC_ST_OFF,
		PWRC_ST_SOFTSTART,
		PWRC_ST_DELAY,
		PWRC_ST_RUN
	} pwrc_seq_t;

	typedef enum logic {
		PWRC_PS_NORMAL,
		PWRC_PS_LIGHT
	} pwrc_power_t;

	typedef enum logic {
		PWRC_IND_STANDARD,
		PWRC_IND_COUPLED
	} pwrc_inductor_t;
endpackage : pwrc_pkg

// ===== core/pwrc_sync.sv
// two flip-flop synchroniser, one per bit
// assumes inputs come from pins outside the core clock
`timescale 1ns/1ns
`default_nettype none
module pwrc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// data
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pwrc_sync_state_t;

	pwrc_sync_state_t st;
	pwrc_sync_state_t next_st;

	always_comb begin
		next_st.meta = i_async;
		next_st.stable = st.meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= {RST, RST};
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.stable;
endmodule : pwrc_sync
`default_nettype wire

// ===== core/pwrc_core.sv
// power state and ready control: enable, straps, light load entry, ready output
// assumes analog comparators and soft-start ramp deliver plain logic levels
`timescale 1ns/1ns
`default_nettype none
`include "pwrc_map.svh"
module pwrc_core #(
	parameter int HOLDOFF_CYCLES = `PWRC_HOLDOFF_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// controller enable and straps
	input wire logic i_enable,
	input wire logic i_frequency_set_strap,
	input wire logic i_phase3_sense_neg,
	input wire logic i_ramp_set_strap,
	input wire logic [`PWRC_CODE_W-1:0] i_voltage_code,
	// analog status levels
	input wire logic i_softstart_done,
	input wire logic i_over_voltage,
	input wire logic i_under_voltage,
	input wire logic i_over_current,
	// platform inputs
	input wire logic i_light_load_request_n,
	input wire logic i_host_reset_n,
	// regulation control
	output logic o_regulate_en,
	output var pwrc_pkg::pwrc_inductor_t o_inductor_mode,
	output logic o_two_phase,
	output logic [`PWRC_CHAN_N-1:0] o_channel_en,
	output logic [`PWRC_CODE_W-1:0] o_reference_code,
	output var pwrc_pkg::pwrc_power_t o_power_state,
	output logic o_bypass_rail,
	// ready pin, open drain
	output logic o_output_ready,
	output logic o_output_ready_oe
);
	import pwrc_pkg::*;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int SW = 8 + `PWRC_CODE_W;
	logic [SW-1:0] raw;
	logic [SW-1:0] syn;
	assign raw = {i_enable, i_frequency_set_strap, i_phase3_sense_neg, i_ramp_set_strap,
		i_softstart_done, i_over_voltage | i_under_voltage | i_over_current,
		i_light_load_request_n, i_host_reset_n, i_voltage_code};

	pwrc_sync #(
		.W(SW),
		.RST({8'h03, `PWRC_CODE_RST})
	) u_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(raw),
		.o_sync(syn)
	);

	logic en_s;
	logic fs_s;
	logic p3_s;
	logic ramp_s;
	logic ss_s;
	logic fault_s;
	logic llr_n_s;
	logic hrst_n_s;
	logic [`PWRC_CODE_W-1:0] code_s;
	assign {en_s, fs_s, p3_s, ramp_s, ss_s, fault_s, llr_n_s, hrst_n_s, code_s} = syn;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pwrc_seq_t seq;
		logic [`PWRC_CNT_W-1:0] rdy_cnt;
		logic [`PWRC_CNT_W-1:0] hold_cnt;
		logic permit;
		logic [`PWRC_CNT_W-1:0] hrst_age;
		pwrc_power_t power;
		logic regulate;
		logic coupled;
		logic two_phase;
		logic rail;
		logic [`PWRC_CODE_W-1:0] code;
		logic ready_low;
	} pwrc_state_t;

	pwrc_state_t st;
	pwrc_state_t next_st;

	localparam logic [`PWRC_CNT_W-1:0] READY_LAST =
		`PWRC_CNT_W'(`PWRC_READY_DELAY_CYCLES - 1);
	localparam logic [`PWRC_CNT_W-1:0] HOLD_LAST = `PWRC_CNT_W'(HOLDOFF_CYCLES - 1);
	localparam logic [`PWRC_CNT_W-1:0] HOLD_FULL = `PWRC_CNT_W'(HOLDOFF_CYCLES);

	always_comb begin
		next_st = st;
		next_st.regulate = en_s;
		next_st.coupled = fs_s;
		next_st.two_phase = p3_s;
		next_st.rail = ramp_s ? `PWRC_RAIL_775 : `PWRC_RAIL_575;
		next_st.code = code_s;

		// ready sequence
		case (st.seq)
			PWRC_ST_OFF: begin
				next_st.rdy_cnt = '0;
				if (en_s) begin
					next_st.seq = PWRC_ST_SOFTSTART;
				end
			end
			PWRC_ST_SOFTSTART: begin
				next_st.rdy_cnt = '0;
				if (ss_s) begin
					next_st.seq = PWRC_ST_DELAY;
				end
			end
			PWRC_ST_DELAY: begin
				if (st.rdy_cnt == READY_LAST) begin
					next_st.seq = PWRC_ST_RUN;
				end else begin
					next_st.rdy_cnt = st.rdy_cnt + 1'b1;
				end
			end
			PWRC_ST_RUN: begin
				next_st.rdy_cnt = st.rdy_cnt;
			end
			default: begin
				next_st.seq = PWRC_ST_OFF;
			end
		endcase
		if (!en_s) begin
			next_st.seq = PWRC_ST_OFF;
		end
		// ready pin pulled low unless running and fault free
		next_st.ready_low = !(next_st.seq == PWRC_ST_RUN) || fault_s || !en_s;

		// post reset hold-off
		if (!hrst_n_s) begin
			next_st.hold_cnt = '0;
			next_st.permit = 1'b0;
		end else if (!st.permit) begin
			if (st.hold_cnt == HOLD_LAST) begin
				next_st.permit = 1'b1;
			end else begin
				next_st.hold_cnt = st.hold_cnt + 1'b1;
			end
		end
		// age of host reset release, watched by the checks
		if (!hrst_n_s) begin
			next_st.hrst_age = '0;
		end else if (st.hrst_age != HOLD_FULL) begin
			next_st.hrst_age = st.hrst_age + 1'b1;
		end

		// power state
		case (st.power)
			PWRC_PS_NORMAL: begin
				if (!llr_n_s && st.permit && hrst_n_s && en_s) begin
					next_st.power = PWRC_PS_LIGHT;
				end
			end
			PWRC_PS_LIGHT: begin
				if (llr_n_s || !hrst_n_s || !en_s) begin
					next_st.power = PWRC_PS_NORMAL;
				end
			end
			default: begin
				next_st.power = PWRC_PS_NORMAL;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st.seq <= PWRC_ST_OFF;
			st.rdy_cnt <= '0;
			st.hold_cnt <= '0;
			st.permit <= 1'b0;
			st.hrst_age <= '0;
			st.power <= PWRC_PS_NORMAL;
			st.regulate <= 1'b0;
			st.coupled <= 1'b0;
			st.two_phase <= 1'b0;
			st.rail <= `PWRC_RAIL_575;
			st.code <= `PWRC_CODE_RST;
			st.ready_low <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_regulate_en = st.regulate;
	assign o_inductor_mode = st.coupled ? PWRC_IND_COUPLED : PWRC_IND_STANDARD;
	assign o_two_phase = st.two_phase;
	assign o_reference_code = st.code;
	assign o_power_state = st.power;
	assign o_bypass_rail = st.rail;
	assign o_output_ready = 1'b0;
	assign o_output_ready_oe = st.ready_low;

	genvar g;
	generate
		for (g = 0; g < `PWRC_CHAN_N; g++) begin : g_chan
			if (g == `PWRC_CHAN3) begin : g_c3
				assign o_channel_en[g] = st.regulate && !st.two_phase;
			end else begin : g_cx
				assign o_channel_en[g] = st.regulate;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_ch3_two_phase: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.two_phase |-> !o_channel_en[`PWRC_CHAN3])
		else $error("channel 3 enabled in two phase mode");

	chk_disable_stops: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!en_s |=> !o_regulate_en && o_output_ready_oe)
		else $error("regulation active while disabled");

	chk_ready_fault: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		fault_s |=> o_output_ready_oe)
		else $error("ready released during fault");

	chk_ready_pre_ss: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.seq == PWRC_ST_SOFTSTART) |-> o_output_ready_oe)
		else $error("ready released before soft-start end");

	chk_ready_delay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(st.seq == PWRC_ST_DELAY) |-> o_output_ready_oe [*8])
		else $error("ready released without delay");

	chk_ready_od: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_output_ready)
		else $error("ready pin driven high");

	chk_reset_blocks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!hrst_n_s |=> o_power_state == PWRC_PS_NORMAL && !st.permit)
		else $error("light load while host reset low");

	chk_request_exit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		llr_n_s |=> o_power_state == PWRC_PS_NORMAL)
		else $error("light load while request high");

	chk_request_enter: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!llr_n_s && st.permit && hrst_n_s && en_s) |=> o_power_state == PWRC_PS_LIGHT)
		else $error("light load request not honoured");

	chk_holdoff_fresh: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(hrst_n_s) |=> !st.permit [*2])
		else $error("entry permitted right after host reset");

	chk_strap_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		fs_s |=> o_inductor_mode == PWRC_IND_COUPLED)
		else $error("inductor mode not following strap");

	chk_standard_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!fs_s |=> o_inductor_mode == PWRC_IND_STANDARD)
		else $error("standard inductor mode not following strap");

	chk_enable_runs: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		en_s |=> o_regulate_en)
		else $error("regulation off while enabled");

	chk_off_on_disable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!en_s |=> st.seq == PWRC_ST_OFF)
		else $error("sequence not restarted on disable");

	chk_channels_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!en_s |=> o_channel_en == '0)
		else $error("channel enabled while disabled");

	chk_code_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_reference_code == $past(code_s))
		else $error("reference code not following inputs");

	chk_p3_two_phase: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		p3_s |=> o_two_phase)
		else $error("two phase mode not taken");

	chk_three_phase: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.regulate && !st.two_phase) |-> o_channel_en[`PWRC_CHAN3])
		else $error("channel 3 off in three phase mode");

	chk_ch12_enabled: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.regulate |-> o_channel_en[1:0] == 2'b11)
		else $error("channel 1 or 2 off while regulating");

	chk_rail_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!ramp_s |=> o_bypass_rail == `PWRC_RAIL_575)
		else $error("bypass rail not at low level");

	chk_rail_high: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ramp_s |=> o_bypass_rail == `PWRC_RAIL_775)
		else $error("bypass rail not at high level");

	chk_delay_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(st.seq == PWRC_ST_RUN) |-> st.rdy_cnt == READY_LAST)
		else $error("ready delay cut short");

	chk_ready_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.seq == PWRC_ST_RUN && !fault_s && en_s) |=> !o_output_ready_oe)
		else $error("ready held low while running fault free");

	chk_ready_run_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_output_ready_oe |-> st.seq == PWRC_ST_RUN)
		else $error("ready released outside run");

	chk_light_permit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_power_state == PWRC_PS_LIGHT) |-> $past(st.permit) && $past(hrst_n_s))
		else $error("light load entered without permission");

	chk_permit_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(st.permit) |-> st.hold_cnt == HOLD_LAST)
		else $error("entry permitted before hold-off count");

	chk_permit_early: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.permit |-> st.hrst_age == HOLD_FULL)
		else $error("entry permitted before hold-off ended");

	chk_permit_late: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.hrst_age == HOLD_FULL) |-> st.permit)
		else $error("entry not permitted after hold-off");

	chk_holdoff_restart: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$fell(hrst_n_s) |=> st.hold_cnt == '0 && !st.permit)
		else $error("hold-off counter not restarted");
endmodule : pwrc_core
`default_nettype wire

// ===== tb/pwrc_platform.sv
// platform model: drives light load request and host reset
// assumes the bench calls drive from its main sequence
`timescale 1ns/1ns
`default_nettype none
module pwrc_platform (
	input wire logic i_clk,
	output logic o_light_load_request_n,
	output logic o_host_reset_n
);
	initial begin
		o_light_load_request_n = 1'b1;
		o_host_reset_n = 1'b0;
	end
	task drive(input logic req_n, input logic rst_n);
		@(posedge i_clk);
		o_light_load_request_n <= req_n;
		o_host_reset_n <= rst_n;
	endtask : drive
endmodule : pwrc_platform
`default_nettype wire

// ===== tb/tb.sv
// bench of pwrc_core with a platform model on the request pins
// assumes a short hold-off parameter and 3 edge input latency
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pwrc_pkg::*;
	localparam int HOLD = 20;
	logic i_clk, i_reset_n, en, fss, p3, rss, ssd, ov, uv, oc;
	logic [7:0] code;
	wire logic req_n, hrst_n;
	logic reg_en, two, rail, oe, rdy, ps_b;
	logic [2:0] ch;
	logic [7:0] ref_code;
	pwrc_inductor_t ind;
	pwrc_power_t ps;
	int n_errors, checks_done;
	logic [31:0] lfsr;
	logic [17:0] qv[$], qm[$], ev, em;
	wire logic [17:0] obs = {ref_code, reg_en, ind, two, ch, ps, rail, oe, rdy};
	pwrc_core #(.HOLDOFF_CYCLES(HOLD)) pwrc_core_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_enable(en), .i_frequency_set_strap(fss), .i_phase3_sense_neg(p3),
		.i_ramp_set_strap(rss), .i_voltage_code(code), .i_softstart_done(ssd),
		.i_over_voltage(ov), .i_under_voltage(uv), .i_over_current(oc),
		.i_light_load_request_n(req_n), .i_host_reset_n(hrst_n), .o_regulate_en(reg_en),
		.o_inductor_mode(ind), .o_two_phase(two), .o_channel_en(ch),
		.o_reference_code(ref_code), .o_power_state(ps), .o_bypass_rail(rail),
		.o_output_ready(rdy), .o_output_ready_oe(oe));
	pwrc_platform pwrc_platform_i (.i_clk(i_clk), .o_light_load_request_n(req_n),
		.o_host_reset_n(hrst_n));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	task tally_and_finish;
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task step(input int n);
		repeat (n) @(posedge i_clk);
	endtask : step
	task chk(input logic [17:0] v, input logic [17:0] m);
		qv.push_back(v);
		qm.push_back(m);
	endtask : chk
	task wait_ready(input int lo, input int hi);
		int k;
		k = 0;
		while (oe !== 1'b0 && k <= hi) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		checks_done++;
		if (k < lo || k > hi) begin
			n_errors++;
			$display("[FAIL] %0t exp %h got %h", $time, lo, k);
			if (k > hi) tally_and_finish();
		end
	endtask : wait_ready
	// ------------------------------------------------------------
	// monitor: oldest note against settled outputs
	// ------------------------------------------------------------
	always @(negedge i_clk) begin
		if (qv.size() > 0) begin
			ev = qv.pop_front();
			em = qm.pop_front();
			checks_done++;
			if ((obs & em) !== (ev & em)) begin
				n_errors++;
				$display("[FAIL] %0t exp %h got %h", $time, ev & em, obs & em);
			end
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		i_reset_n = 1'b0;
		{en, fss, p3, rss, ssd, ov, uv, oc} = 8'h00;
		code = 8'h00;
		lfsr = 32'h05684ea6;
		n_errors = 0;
		checks_done = 0;
		step(4);
		i_reset_n <= 1'b1;
		step(4);
		chk(18'h00002, 18'h3ffff);
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clk);
			lfsr = lfsr_next(lfsr);
			en <= 1'b1;
			code <= lfsr[7:0];
			{rss, p3, fss} <= i[2:0];
			step(4);
			chk({lfsr[7:0], 1'b1, i[0], i[1], i[1] ? 3'b011 : 3'b111, 1'b0, i[2], 2'b10},
				18'h3ffff);
		end
		@(posedge i_clk);
		ssd <= 1'b1;
		wait_ready(1003, 1003);
		chk(18'h00000, 18'h00003);
		for (int f = 0; f < 3; f++) begin
			@(posedge i_clk);
			{oc, uv, ov} <= 3'b001 << f;
			step(4);
			chk(18'h00002, 18'h00003);
			@(posedge i_clk);
			{oc, uv, ov} <= 3'b000;
			wait_ready(3, 3);
		end
		@(posedge i_clk);
		en <= 1'b0;
		step(4);
		chk(18'h00002, 18'h00272);
		@(posedge i_clk);
		en <= 1'b1;
		pwrc_platform_i.drive(1'b0, 1'b0);
		step(HOLD + 12);
		chk(18'h00000, 18'h00008);
		pwrc_platform_i.drive(1'b0, 1'b1);
		step(HOLD - 2);
		chk(18'h00000, 18'h00008);
		pwrc_platform_i.drive(1'b0, 1'b0);
		pwrc_platform_i.drive(1'b0, 1'b1);
		step(HOLD - 2);
		chk(18'h00000, 18'h00008);
		step(12);
		chk(18'h00008, 18'h00008);
		pwrc_platform_i.drive(1'b1, 1'b1);
		step(4);
		chk(18'h00000, 18'h00008);
		pwrc_platform_i.drive(1'b0, 1'b1);
		step(4);
		chk(18'h00008, 18'h00008);
		pwrc_platform_i.drive(1'b0, 1'b0);
		step(4);
		chk(18'h00000, 18'h00008);
		step(2);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
